/* inc/nbh_cfg.svh */
`ifndef NBH_CFG_SVH
`define NBH_CFG_SVH
// command codes
`define NBH_CMD_READ_SETUP   8'h00
`define NBH_CMD_READ_CONF    8'h30
`define NBH_CMD_CACHE_CONF   8'h31
`define NBH_CMD_CACHE_EXIT   8'h34
`define NBH_CMD_RDOUT_SETUP  8'h05
`define NBH_CMD_RDOUT_CONF   8'hE0
`define NBH_CMD_PROG_SETUP   8'h80
`define NBH_CMD_PROG_CONF    8'h10
`define NBH_CMD_CPROG_CONF   8'h15
`define NBH_CMD_RDIN         8'h85
`define NBH_CMD_COPY_CONF    8'h35
`define NBH_CMD_ERASE_SETUP  8'h60
`define NBH_CMD_ERASE_CONF   8'hD0
`define NBH_CMD_RESET        8'hFF
`define NBH_CMD_SIG          8'h90
`define NBH_CMD_STATUS       8'h70
`define NBH_CMD_LOCK_STAT    8'h7A
`define NBH_CMD_UNLOCK_A     8'h23
`define NBH_CMD_UNLOCK_B     8'h24
`define NBH_CMD_LOCK         8'h2A
`define NBH_CMD_LOCKDOWN     8'h2C
// address layout
`define NBH_ADDR_W           31
`define NBH_ADDR_CYCLES      3'd5
`define NBH_COL_CYCLES       3'd2
`define NBH_CYC2_MASK        8'h0F
`define NBH_CYC5_MASK        8'h07
// strobe phase: each half of a write or read strobe lasts at least this many ns, rounded up to whole clocks
`define NBH_STROBE_NS        100
`define NBH_CLK_NS           100
`define NBH_PHASE_CYC        ((`NBH_STROBE_NS + `NBH_CLK_NS - 1) / `NBH_CLK_NS)
`endif

/* inc/nbh_pkg.sv */
package nbh_pkg;
  // kind of bus step requested by the user side
  typedef enum logic [1:0]
  {
    NBH_OP_CMD  = 2'b00,
    NBH_OP_ADDR = 2'b01,
    NBH_OP_DIN  = 2'b10,
    NBH_OP_DOUT = 2'b11
  } nbh_op_t;

  typedef struct packed
  {
    nbh_op_t     op;
    logic [30:0] addr;
    logic [7:0]  data;
    logic [2:0]  ncyc;
  } nbh_req_t;

  typedef struct packed
  {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic       wp_n;
    logic [7:0] dq_o;
    logic       dq_oe_n;
  } nbh_pins_t;

  typedef enum logic [2:0]
  {
    NBH_ST_IDLE  = 3'b000,
    NBH_ST_SETUP = 3'b001,
    NBH_ST_LOW   = 3'b010,
    NBH_ST_HIGH  = 3'b011,
    NBH_ST_NEXT  = 3'b100
  } nbh_state_t;
endpackage

/* design/nbh_skid.sv */
`timescale 1ns/100ps
`default_nettype none
module nbh_skid
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [7:0]      out_data
);
  import nbh_pkg::*;

  typedef struct packed
  {
    logic [1:0][7:0] mem;
    logic            wr;
    logic            rd;
    logic [1:0]      cnt;
  } nbh_skid_t;

  nbh_skid_t s_q;
  nbh_skid_t s_d;

  // two entries: a stalled receiver never costs a byte already on the wire
  always_comb
  begin
    s_d = s_q;
    if (in_valid && in_ready)
    begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = ~s_q.wr;
    end
    if (out_valid && out_ready)
      s_d.rd = ~s_q.rd;
    s_d.cnt = s_q.cnt + {1'b0, in_valid && in_ready} - {1'b0, out_valid && out_ready};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign in_ready  = (s_q.cnt != 2'd2);
  assign out_valid = (s_q.cnt != 2'd0);
  assign out_data  = s_q.mem[s_q.rd];

  never_overfill_a: assert property (@(posedge clk) disable iff (rst) s_q.cnt <= 2'd2)
    else $error("buffer count over two");
endmodule
`default_nettype wire

/* design/nbh_host.sv */
`timescale 1ns/100ps
`default_nettype none
`include "nbh_cfg.svh"
// Summary of operation
// RULE1: device drives data only with chip select low, write high, latches low.
// RULE2: each read strobe fall gives the next output byte.
// RULE3: output path carries array, status, lock, signature and identifier bytes.
// RULE4: write protect low refuses all program and erase.
// RULE5: write protect is level sensed continuously, not latched.
// RULE6: host keeps write protect high while issuing program or erase codes.
// RULE7: chip select high puts the device in standby, outputs off.
// RULE8: address goes in five bytes, unused upper bits low.
// RULE9: device ignores address bytes beyond those needed.
// RULE10: column bits 0-11, page 12-17, block 18 upward.
// RULE11: command taken on write rise while command latch high.
// RULE12: program and erase need setup code then confirm code.
// RULE13: page read 00h then 30h, cache read 00h then 31h.
// RULE14: exit cache read 34h accepted busy only in cache read.
// RULE15: random data out is 05h, column, E0h.
// RULE16: program 80h/10h, cache program 80h/15h, random input 85h.
// RULE17: copy back is 00h, 35h, 85h, 10h with addresses between.
// RULE18: erase is 60h, block address, D0h.
// RULE19: while busy only reset, status and cache exit are accepted.
// RULE20: signature 90h, lock status 7Ah.
// RULE21: unlock 23h then 24h, lock 2Ah, lock-down 2Ch.
// RULE22: address taken on write rise, address latch high, others idle.
// RULE23: each read fall advances the column counter.
// RULE24: data in taken on write rise with both latches low.
// RULE25: undefined codes are ignored by the device.
module nbh_host
(
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic             REQ_VALID,
  output logic                  REQ_READY,
  input  wire nbh_pkg::nbh_req_t REQ,
  input  wire logic             WP_ALLOW,
  output logic                  CMD_REFUSED,
  output logic                  RSP_VALID,
  input  wire logic             RSP_READY,
  output logic [7:0]            RSP_DATA,
  output logic                  DEV_BUSY,
  input  wire logic             BUSY_FLAG_N,
  input  wire logic [7:0]       DQ_I,
  output logic                  CE_N,
  output logic                  COMMAND_LATCH_STROBE,
  output logic                  ADDRESS_LATCH_STROBE,
  output logic                  WE_N,
  output logic                  RE_N,
  output logic                  WP_N,
  output logic [7:0]            DQ_O,
  output logic                  DQ_OE_N
);
  import nbh_pkg::*;

  localparam logic [7:0] PHASE = 8'(`NBH_PHASE_CYC);

  typedef struct packed
  {
    nbh_state_t  st;
    nbh_req_t    req;
    logic [2:0]  idx;
    logic [7:0]  tmr;
    nbh_pins_t   pin;
    logic        cache_q;
    logic        refused;
    logic        cap_valid;
    logic [7:0]  cap_data;
  } nbh_host_t;

  nbh_host_t s_q;
  nbh_host_t s_d;
  logic      fifo_ready;

  // true for codes that alter the array
  function automatic logic is_pe(input logic [7:0] c);
    is_pe = (c == `NBH_CMD_PROG_SETUP) || (c == `NBH_CMD_PROG_CONF) ||  // [RULE12] [RULE16]
            (c == `NBH_CMD_CPROG_CONF) || (c == `NBH_CMD_ERASE_SETUP) ||  // [RULE18]
            (c == `NBH_CMD_ERASE_CONF) || (c == `NBH_CMD_RDIN);
  endfunction

  // codes a busy device takes; others would be ignored there, so hold them back
  function automatic logic ok_busy(input logic [7:0] c, input logic cache);
    ok_busy = (c == `NBH_CMD_RESET) || (c == `NBH_CMD_STATUS) ||
              ((c == `NBH_CMD_CACHE_EXIT) && cache);
  endfunction

  // codes with a defined meaning; a stray code would leave the device state unclear
  function automatic logic is_known(input logic [7:0] c);
    is_known = is_pe(c) || ok_busy(c, 1'b1) ||
               (c inside {`NBH_CMD_READ_SETUP, `NBH_CMD_READ_CONF}) ||  // [RULE13]
               (c inside {`NBH_CMD_CACHE_CONF, `NBH_CMD_COPY_CONF}) ||  // [RULE13] [RULE17]
               (c inside {`NBH_CMD_RDOUT_SETUP, `NBH_CMD_RDOUT_CONF}) ||  // [RULE15]
               (c inside {`NBH_CMD_SIG, `NBH_CMD_LOCK_STAT}) ||  // [RULE20]
               (c inside {`NBH_CMD_UNLOCK_A, `NBH_CMD_UNLOCK_B}) ||  // [RULE21]
               (c inside {`NBH_CMD_LOCK, `NBH_CMD_LOCKDOWN});  // [RULE21]
  endfunction

  // byte n of the five-cycle address, unused bits forced low
  function automatic logic [7:0] addr_byte(input logic [30:0] a, input logic [2:0] n);
    unique case (n)
      3'd0:    addr_byte = a[7:0];
      3'd1:    addr_byte = {4'h0, a[11:8]} & `NBH_CYC2_MASK;
      3'd2:    addr_byte = a[19:12];
      3'd3:    addr_byte = a[27:20];
      default: addr_byte = {5'h00, a[30:28]} & `NBH_CYC5_MASK;
    endcase
  endfunction

  //==========================================================================
  // bus sequencer
  always_comb
  begin
    s_d = s_q;
    s_d.cap_valid = 1'b0;
    s_d.refused = 1'b0;
    s_d.pin.wp_n = WP_ALLOW;
    unique case (s_q.st)
      NBH_ST_IDLE:
      begin
        s_d.pin.ce_n = 1'b1;  // standby between requests [RULE7]
        s_d.pin.dq_oe_n = 1'b1;
        if (REQ_VALID)
        begin
          if (REQ.op == NBH_OP_CMD && is_pe(REQ.data) && !WP_ALLOW)
            s_d.refused = 1'b1;  // never send array-altering code under protect [RULE6] [RULE4]
          else if (REQ.op == NBH_OP_CMD && !is_known(REQ.data))
            s_d.refused = 1'b1;  // stray codes never reach the device
          else if (REQ.op == NBH_OP_CMD && !BUSY_FLAG_N && !ok_busy(REQ.data, s_q.cache_q))
            s_d.refused = 1'b1;  // [RULE19] [RULE14]
          else
          begin
            s_d.req = REQ;
            s_d.idx = 3'd0;
            s_d.tmr = PHASE;
            s_d.st = NBH_ST_SETUP;
            s_d.pin.ce_n = 1'b0;
            s_d.pin.cle = (REQ.op == NBH_OP_CMD);   // [RULE11]
            s_d.pin.ale = (REQ.op == NBH_OP_ADDR);  // [RULE22]
            s_d.pin.dq_oe_n = (REQ.op == NBH_OP_DOUT);  // [RULE1]
            if (REQ.op == NBH_OP_CMD)
            begin
              // cache state tracked for busy-time exit [RULE13] [RULE14]
              if (REQ.data == `NBH_CMD_CACHE_CONF)
                s_d.cache_q = 1'b1;
              else if (REQ.data == `NBH_CMD_CACHE_EXIT || REQ.data == `NBH_CMD_RESET)
                s_d.cache_q = 1'b0;
            end
          end
        end
      end
      NBH_ST_SETUP:
      begin
        s_d.tmr = s_q.tmr - 8'd1;
        if (s_q.tmr == 8'd1)
        begin
          s_d.tmr = PHASE;
          s_d.st = NBH_ST_LOW;
          if (s_q.req.op == NBH_OP_DOUT)
            s_d.pin.re_n = 1'b0;  // falling read strobe fetches next byte [RULE2] [RULE23]
          else
          begin
            s_d.pin.we_n = 1'b0;
            unique case (s_q.req.op)
              NBH_OP_ADDR: s_d.pin.dq_o = addr_byte(s_q.req.addr, s_q.idx);  // [RULE8]
              default:     s_d.pin.dq_o = s_q.req.data;  // [RULE24]
            endcase
          end
        end
      end
      NBH_ST_LOW:
      begin
        s_d.tmr = s_q.tmr - 8'd1;
        // a full buffer holds the read strobe low rather than drop a byte
        if (s_q.tmr == 8'd1 && (s_q.req.op != NBH_OP_DOUT || fifo_ready))
        begin
          s_d.tmr = PHASE;
          s_d.st = NBH_ST_HIGH;
          s_d.pin.we_n = 1'b1;  // rising edge latches the byte [RULE11] [RULE22] [RULE24]
          s_d.pin.re_n = 1'b1;
          if (s_q.req.op == NBH_OP_DOUT)
          begin
            s_d.cap_valid = 1'b1;  // any source: array, status, id [RULE3]
            s_d.cap_data = DQ_I;
          end
        end
        else if (s_q.tmr == 8'd1)
          s_d.tmr = 8'd1;
      end
      NBH_ST_HIGH:
      begin
        s_d.tmr = s_q.tmr - 8'd1;
        if (s_q.tmr == 8'd1)
          s_d.st = NBH_ST_NEXT;
      end
      default:
      begin
        // address stops at five bytes, column-only steps at ncyc [RULE9] [RULE10]
        if (s_q.req.op != NBH_OP_CMD && (s_q.idx + 3'd1) < s_q.req.ncyc &&
            !(s_q.req.op == NBH_OP_ADDR && (s_q.idx + 3'd1) >= `NBH_ADDR_CYCLES))
        begin
          s_d.idx = s_q.idx + 3'd1;
          s_d.tmr = PHASE;
          s_d.st = NBH_ST_SETUP;
        end
        else
        begin
          s_d.st = NBH_ST_IDLE;
          s_d.pin.cle = 1'b0;
          s_d.pin.ale = 1'b0;
          s_d.pin.ce_n = 1'b1;
          s_d.pin.dq_oe_n = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      s_q <= '0;
      s_q.pin.ce_n <= 1'b1;
      s_q.pin.we_n <= 1'b1;
      s_q.pin.re_n <= 1'b1;
      s_q.pin.dq_oe_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  nbh_skid u_buf
  (
    .clk       (CLK),
    .rst       (RST),
    .in_valid  (s_q.cap_valid),
    .in_ready  (fifo_ready),
    .in_data   (s_q.cap_data),
    .out_valid (RSP_VALID),
    .out_ready (RSP_READY),
    .out_data  (RSP_DATA)
  );

  assign REQ_READY            = (s_q.st == NBH_ST_IDLE);
  assign CMD_REFUSED          = s_q.refused;
  assign DEV_BUSY             = s_q.cache_q;
  assign CE_N                 = s_q.pin.ce_n;
  assign COMMAND_LATCH_STROBE = s_q.pin.cle;
  assign ADDRESS_LATCH_STROBE = s_q.pin.ale;
  assign WE_N                 = s_q.pin.we_n;
  assign RE_N                 = s_q.pin.re_n;
  assign WP_N                 = s_q.pin.wp_n;
  assign DQ_O                 = s_q.pin.dq_o;
  assign DQ_OE_N              = s_q.pin.dq_oe_n;

  //==========================================================================
  // checks
  sequence read_fall_s;
    !RE_N && $past(RE_N);
  endsequence

  read_latch_idle_a: assert property (@(posedge CLK) disable iff (RST) // [RULE1]
    !RE_N |-> !CE_N && WE_N && !COMMAND_LATCH_STROBE && !ADDRESS_LATCH_STROBE && DQ_OE_N)
    else $error("read strobe low with bad latch state");
  pe_protect_a: assert property (@(posedge CLK) disable iff (RST) // [RULE6]
    !WE_N && COMMAND_LATCH_STROBE && is_pe(DQ_O) |-> WP_N)
    else $error("program code sent under protect");
  cmd_strobe_a: assert property (@(posedge CLK) disable iff (RST) // [RULE11]
    $rose(WE_N) && COMMAND_LATCH_STROBE |-> !CE_N && !ADDRESS_LATCH_STROBE && RE_N)
    else $error("command latched with bad strobes");
  addr_strobe_a: assert property (@(posedge CLK) disable iff (RST) // [RULE22]
    $rose(WE_N) && ADDRESS_LATCH_STROBE |-> !CE_N && !COMMAND_LATCH_STROBE && RE_N)
    else $error("address latched with bad strobes");
  addr_count_a: assert property (@(posedge CLK) disable iff (RST) // [RULE9]
    ADDRESS_LATCH_STROBE |-> s_q.idx < 3'd5)
    else $error("too many address cycles");
  read_capture_a: assert property (@(posedge CLK) disable iff (RST) // [RULE2]
    $rose(RE_N) |-> s_q.cap_valid)
    else $error("read pulse ended without a captured byte");
  read_fall_a: assert property (@(posedge CLK) disable iff (RST) // [RULE23]
    read_fall_s |-> s_q.st == NBH_ST_LOW && s_q.req.op == NBH_OP_DOUT)
    else $error("read strobe fell outside a read step");
  busy_hold_a: assert property (@(posedge CLK) disable iff (RST) // [RULE19]
    $fell(WE_N) && COMMAND_LATCH_STROBE && !BUSY_FLAG_N |->
      ok_busy(DQ_O, $past(s_q.cache_q, `NBH_PHASE_CYC + 1)))
    else $error("command issued to busy device");
  standby_a: assert property (@(posedge CLK) disable iff (RST) // [RULE7]
    CE_N |-> DQ_OE_N && WE_N && RE_N)
    else $error("strobes active in standby");
  cyc2_mask_a: assert property (@(posedge CLK) disable iff (RST) // [RULE8]
    !WE_N && ADDRESS_LATCH_STROBE && s_q.idx == 3'd1 |-> DQ_O[7:4] == 4'h0)
    else $error("address cycle two upper nibble set");
endmodule
`default_nettype wire

/* sim/nbh_dev_model.sv */
`timescale 1ns/100ps
`default_nettype none
module nbh_dev_model
#(
  parameter int         BUSY_CYC  = 20,
  parameter logic [7:0] SIG_BYTE  = 8'hA5, // arbitrary value
  parameter logic [7:0] STAT_BYTE = 8'hE0
)
(
  input  wire logic       clk,
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic       wp_n,
  input  wire logic [7:0] dq_in,
  output logic [7:0]      dq_out,
  output logic            busy_n
);
  logic [7:0]  last_cmd, mode, dbyte, obyte;
  logic [7:0]  ab [5];
  logic [11:0] col;
  int          acnt, bcnt, prog_cnt;
  wire [11:0]  a_col  = {ab[1][3:0], ab[0]};
  wire [5:0]   a_page = ab[2][5:0];
  wire [12:0]  a_blk  = {ab[4][2:0], ab[3], ab[2][7:6]};
  initial
  begin
    last_cmd = 8'h00;
    mode = 8'h30;
    dbyte = 8'h00;
    obyte = 8'h00;
    col = 12'h000;
    acnt = 0;
    bcnt = 0;
    prog_cnt = 0;
  end
  assign busy_n = (bcnt == 0);
  // released bus shows the inverse so a late sample cannot pass by luck
  assign dq_out = (!ce_n && we_n && !ale && !cle) ? obyte : ~obyte;
  always @(posedge clk)
    if (bcnt > 0)
      bcnt--;
  always @(posedge we_n)
    if (!ce_n && re_n)
    begin
      if (cle && !ale && (busy_n || dq_in inside {8'hFF, 8'h70}
          || (dq_in == 8'h34 && mode == 8'h31)))
      begin
        if (dq_in inside {8'h00, 8'h30, 8'h31, 8'h34, 8'h05, 8'hE0, 8'h80, 8'h10, 8'h15,
            8'h85, 8'h35, 8'h60, 8'hD0, 8'hFF, 8'h90, 8'h70, 8'h7A, 8'h23, 8'h24, 8'h2A,
            8'h2C})
        begin
          last_cmd = dq_in;
          acnt = 0;
          if (dq_in inside {8'h30, 8'h31, 8'h35, 8'hE0})
            col = a_col;
          if (dq_in inside {8'h30, 8'h31, 8'h35})
            bcnt = BUSY_CYC;
          if (dq_in inside {8'h10, 8'h15, 8'hD0} && wp_n)
          begin
            prog_cnt++;
            bcnt = BUSY_CYC;
          end
          if (dq_in inside {8'h30, 8'h31, 8'h70, 8'h7A, 8'h90})
            mode = dq_in;
        end
      end
      else if (ale && !cle && acnt < 5)
      begin
        ab[acnt] = dq_in;
        acnt++;
      end
      else if (!ale && !cle)
        dbyte = dq_in;
    end
  always @(negedge re_n)
    if (!ce_n)
    begin
      case (mode)
        8'h70:   obyte = STAT_BYTE;
        8'h90:   obyte = SIG_BYTE;
        8'h7A:   obyte = 8'h01;
        default: obyte = col[7:0] ^ 8'h5A;
      endcase
      col = col + 12'h001;
    end
endmodule
`default_nettype wire

/* sim/tb_nbh_host.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_nbh_host;
  import nbh_pkg::*;
  logic       CLK, RST, REQ_VALID, WP_ALLOW, RSP_READY, rf;
  nbh_req_t   REQ;
  logic       REQ_READY, CMD_REFUSED, RSP_VALID, DEV_BUSY, BUSY_FLAG_N;
  logic       CE_N, CLE, ALE, WE_N, RE_N, WP_N, DQ_OE_N;
  logic [7:0] RSP_DATA, DQ_I, DQ_O, dev_q, b;
  int         err_total, n_compared, pc;
  assign DQ_I = DQ_OE_N ? dev_q : DQ_O;
  nbh_host nbh_host_i (.CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
    .REQ(REQ), .WP_ALLOW(WP_ALLOW), .CMD_REFUSED(CMD_REFUSED), .RSP_VALID(RSP_VALID),
    .RSP_READY(RSP_READY), .RSP_DATA(RSP_DATA), .DEV_BUSY(DEV_BUSY),
    .BUSY_FLAG_N(BUSY_FLAG_N), .DQ_I(DQ_I), .CE_N(CE_N), .COMMAND_LATCH_STROBE(CLE),
    .ADDRESS_LATCH_STROBE(ALE), .WE_N(WE_N), .RE_N(RE_N), .WP_N(WP_N), .DQ_O(DQ_O),
    .DQ_OE_N(DQ_OE_N));
  nbh_dev_model nbh_dev_model_i (.clk(CLK), .ce_n(CE_N), .cle(CLE), .ale(ALE), .we_n(WE_N),
    .re_n(RE_N), .wp_n(WP_N), .dq_in(DQ_I), .dq_out(dev_q), .busy_n(BUSY_FLAG_N));
  initial CLK = 1'b0;
  always #50 CLK = ~CLK;
  // ==========
  // shared tasks
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    n_compared++;
    if (!ok)
    begin
      err_total++;
      $display("mismatch t=%0t %s", $time, m);
    end
  endtask
  task automatic issue(input nbh_op_t op, input logic [30:0] a, input logic [7:0] d,
                       input logic [2:0] n);
    @(posedge CLK);
    REQ_VALID <= 1'b1;
    REQ <= '{op, a, d, n};
    do @(negedge CLK); while (REQ_READY !== 1'b1);
    @(posedge CLK);
    REQ_VALID <= 1'b0;
    rf = 1'b0;
    for (int i = 0; i < 100; i++)
    begin
      @(negedge CLK);
      if (CMD_REFUSED === 1'b1)
        rf = 1'b1;
      if (i > 0 && REQ_READY === 1'b1)
        break;
    end
    if (REQ_READY !== 1'b1)
    begin
      err_total++;
      $display("mismatch t=%0t request hang", $time);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    issue(NBH_OP_CMD, 31'h0, c, 3'h0);
  endtask
  task automatic wait_rdy;
    for (int i = 0; i < 200 && BUSY_FLAG_N !== 1'b1; i++)
      @(negedge CLK);
    if (BUSY_FLAG_N !== 1'b1)
    begin
      err_total++;
      $display("mismatch t=%0t device stays busy", $time);
    end
  endtask
  task automatic get(input logic [7:0] e, input string m);
    logic v;
    @(posedge CLK);
    RSP_READY <= 1'b1;
    for (int i = 0; i < 100; i++)
    begin
      @(negedge CLK);
      if (RSP_VALID === 1'b1)
        break;
    end
    v = RSP_VALID;
    b = RSP_DATA;
    @(posedge CLK);
    RSP_READY <= 1'b0;
    chk(v === 1'b1 && b === e, m);
  endtask
  // ==========
  // scenarios
  task automatic t_addr;
    logic [30:0] a;
    a = 31'h5BCD_E123;
    cmd(8'h00);
    issue(NBH_OP_ADDR, a, 8'h00, 3'h5);
    chk(nbh_dev_model_i.ab[1] === {4'h0, a[11:8]}, "cycle 2");
    chk(nbh_dev_model_i.ab[4] === {5'h0, a[30:28]}, "cycle 5");
    chk(nbh_dev_model_i.a_col === a[11:0] && nbh_dev_model_i.a_page === a[17:12]
        && nbh_dev_model_i.a_blk === a[30:18], "fields");
    chk(CE_N === 1'b1 && nbh_dev_model_i.last_cmd === 8'h00, "idle");
  endtask
  task automatic t_read;
    cmd(8'h00);
    issue(NBH_OP_ADDR, 31'h0000_1004, 8'h00, 3'h5);
    cmd(8'h30);
    wait_rdy();
    fork
      issue(NBH_OP_DOUT, 31'h0, 8'h00, 3'h4);
      begin
        // two bytes fill the buffer; the third read must wait with its strobe low
        repeat (20) @(negedge CLK);
        chk(RE_N === 1'b0 && RSP_VALID === 1'b1, "stall holds strobe");
        for (int k = 0; k < 4; k++)
          get(8'(k + 4) ^ 8'h5A, "stream");
      end
    join
    cmd(8'h05);
    issue(NBH_OP_ADDR, 31'h0000_0010, 8'h00, 3'h2);
    cmd(8'hE0);
    issue(NBH_OP_DOUT, 31'h0, 8'h00, 3'h1);
    get(8'h10 ^ 8'h5A, "random out");
    cmd(8'h90);
    issue(NBH_OP_DOUT, 31'h0, 8'h00, 3'h1);
    get(8'hA5, "signature");
  endtask
  task automatic t_wp;
    pc = nbh_dev_model_i.prog_cnt;
    cmd(8'h80);
    chk(rf === 1'b1 && WP_N === 1'b0, "wp refuse");
    @(posedge CLK);
    WP_ALLOW <= 1'b1;
    repeat (3) @(negedge CLK);
    chk(WP_N === 1'b1, "wp pin");
    cmd(8'h80);
    issue(NBH_OP_ADDR, 31'h0004_0000, 8'h00, 3'h5);
    issue(NBH_OP_DIN, 31'h0, 8'h3C, 3'h1);
    chk(nbh_dev_model_i.dbyte === 8'h3C, "data in");
    cmd(8'h10);
    chk(rf === 1'b0 && nbh_dev_model_i.prog_cnt == pc + 1, "program");
    wait_rdy();
  endtask
  task automatic t_busy;
    cmd(8'h60);
    issue(NBH_OP_ADDR, 31'h0008_0000, 8'h00, 3'h5);
    cmd(8'hD0);
    cmd(8'h90);
    chk(rf === 1'b1, "busy refuse");
    cmd(8'h70);
    chk(rf === 1'b0 && nbh_dev_model_i.last_cmd === 8'h70, "status busy");
    issue(NBH_OP_DOUT, 31'h0, 8'h00, 3'h1);
    get(8'hE0, "status");
    chk(nbh_dev_model_i.prog_cnt == pc + 2, "erase");
    wait_rdy();
  endtask
  task automatic t_cache;
    cmd(8'h00);
    issue(NBH_OP_ADDR, 31'h0000_2000, 8'h00, 3'h5);
    cmd(8'h31);
    chk(DEV_BUSY === 1'b1 && BUSY_FLAG_N === 1'b0, "cache on");
    cmd(8'h34);
    chk(rf === 1'b0 && DEV_BUSY === 1'b0, "cache exit");
    chk(nbh_dev_model_i.last_cmd === 8'h34, "cache exit taken");
    wait_rdy();
  endtask
  task automatic t_misc;
    cmd(8'h42);
    chk(rf === 1'b1 && nbh_dev_model_i.last_cmd === 8'h34, "stray code");
    cmd(8'h23);
    issue(NBH_OP_ADDR, 31'h0004_0000, 8'h00, 3'h5);
    cmd(8'h24);
    chk(rf === 1'b0 && nbh_dev_model_i.last_cmd === 8'h24, "unlock");
    cmd(8'h2A);
    chk(nbh_dev_model_i.last_cmd === 8'h2A, "lock");
    cmd(8'h2C);
    chk(nbh_dev_model_i.last_cmd === 8'h2C, "lock down");
    cmd(8'h7A);
    issue(NBH_OP_DOUT, 31'h0, 8'h00, 3'h1);
    get(8'h01, "lock status");
    cmd(8'h00);
    issue(NBH_OP_ADDR, 31'h0004_0000, 8'h00, 3'h5);
    cmd(8'h35);
    wait_rdy();
    cmd(8'h85);
    issue(NBH_OP_ADDR, 31'h0004_1000, 8'h00, 3'h5);
    cmd(8'h10);
    chk(rf === 1'b0 && nbh_dev_model_i.prog_cnt == pc + 3, "copy back");
    wait_rdy();
  endtask
  initial
  begin
    #2000000;
    err_total++;
    end_sim();
  end
  initial
  begin
    RST = 1'b1;
    REQ_VALID = 1'b0;
    REQ = '0;
    WP_ALLOW = 1'b0;
    RSP_READY = 1'b0;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    @(negedge CLK);
    chk(CE_N === 1'b1 && WE_N === 1'b1 && RE_N === 1'b1 && DQ_OE_N === 1'b1
        && WP_N === 1'b0 && RSP_VALID === 1'b0, "reset");
    t_addr();
    t_read();
    t_wp();
    t_busy();
    t_cache();
    t_misc();
    end_sim();
  end
endmodule
`default_nettype wire
